// File: hw/sts_supervisor.sv
`timescale 1ns/1ps
`include "sts_consts.svh"
// Contract
// - prewarn comparator sets prewarn flag only
// - undervoltage pulls reset low, restart, flag
// - hysteresis bit: release uses highest rising threshold
// - count each consecutive undervoltage event
// - counter active in init, normal, stop
// - normal mode: battery low stops counter
// - fourth event: fail-safe, set failsafe flag
// - counter cleared: fail-safe, flag clear, soft reset
// - sleep mode sets no supply flags
// - overvoltage sets flag, mode event, 11 fail-safe
// - short detection only with battery above threshold
// - no rise in time: short response, fail-safe
// - low too long: same short response
// - pump overtemp while on: off, block flag
// - pump overtemp: flag, disable, discharge, then off
// - prewarn temperature flag, clear when cool
// - thermal shutdown: fail-safe, cool-down, restart, normal
// - shutdown flag clear in normal when cool
// - count shutdowns, 16 sets safe flag
// - extended cool-down 64x until safe flag cleared
// - shutdown sets flag_a flag and state 01
module sts_supervisor #(
  parameter int unsigned SC_CYCLES = `STS_SC_CYCLES, // short-circuit time
  parameter int unsigned COOL_CYCLES = `STS_COOL_CYCLES // cool-down time
) (
  input wire logic ref_clk,
  input wire logic reset,
  // analog comparators (asynchronous)
  input wire logic cmp_prewarn_low, // output below prewarning level
  input wire logic cmp_below_fall, // output below configured falling threshold
  input wire logic cmp_above_rise_sel, // output above configured rising threshold
  input wire logic cmp_above_rise_high, // output above highest rising threshold
  input wire logic cmp_overvolt, // output above overvoltage threshold
  input wire logic cmp_batt_uv, // battery below undervoltage threshold
  input wire logic cmp_pump_hot, // pump at shutdown temperature
  input wire logic cmp_temp_prewarn, // regulator at prewarning temperature
  input wire logic cmp_temp_shutdown, // device at shutdown temperature
  // control from software / mode logic
  input wire logic reset_hysteresis_sel,
  input wire logic [1:0] overvolt_event_mode,
  input wire logic cooldown_extend_enable,
  input wire logic pump_enable_wr, // pulse: software writes pump enable one
  input wire logic xcross_done, // all active cross-current times elapsed
  input wire logic soft_reset, // pulse
  input wire logic wake_up, // pulse: wake from sleep or fail-safe
  input wire logic sleep_req, // pulse: enter sleep
  input wire logic stop_req, // pulse: enter stop from normal
  input wire logic normal_req, // pulse: enter normal from init/stop
  // clear pulses from software
  input wire logic clr_supply_prewarn,
  input wire logic clr_supply_undervolt,
  input wire logic clr_undervolt_failsafe,
  input wire logic clr_supply_overvolt,
  input wire logic clr_supply_short,
  input wire logic clr_block_tsd,
  input wire logic clr_pump_overtemp,
  input wire logic clr_thermal_prewarn,
  input wire logic clr_device_tsd,
  input wire logic clr_thermal_safe,
  input wire logic clr_flag_a,
  // outputs
  output logic reset_output_n,
  output logic regulator_en,
  output logic fail_output_pin,
  output logic pump_enable,
  output logic pump_discharge,
  output logic pump_csa_en,
  output logic [1:0] overvolt_event, // event type pulse, per mode field
  output sts_pkg::sts_mode_type mode,
  output logic [1:0] device_state_field,
  output logic [2:0] uv_count,
  output logic [4:0] tsd_count,
  output logic supply_prewarn_flag,
  output logic supply_undervolt_flag,
  output logic undervolt_failsafe_flag,
  output logic supply_overvolt_flag,
  output logic supply_short_flag,
  output logic flag_a,
  output logic block_thermal_shutdown_flag,
  output logic pump_overtemp_flag,
  output logic thermal_prewarn_flag,
  output logic device_thermal_shutdown_flag,
  output logic thermal_safe_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: comparators are outside the clock domain
  localparam int NS = 9;
  logic [NS-1:0] sync1; // first stage, read only by sync2
  logic [NS-1:0] sync2; // stable copies
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {cmp_prewarn_low, cmp_below_fall, cmp_above_rise_sel, cmp_above_rise_high,
                cmp_overvolt, cmp_batt_uv, cmp_pump_hot, cmp_temp_prewarn,
                cmp_temp_shutdown};
      sync2 <= sync1;
    end
  end
  logic s_prewarn, s_fall, s_rise_sel, s_rise_high, s_ov, s_batt_uv, s_pump_hot, s_tpw, s_tsd;
  assign {s_prewarn, s_fall, s_rise_sel, s_rise_high, s_ov, s_batt_uv, s_pump_hot, s_tpw,
          s_tsd} = sync2;

  ////////////////////////////////////////////////////////////////////////////
  // edge history for event detection
  logic ov_d; // previous overvoltage level
  logic tsd_d; // previous shutdown level
  logic pump_hot_d; // previous pump temperature level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ov_d <= 1'b0;
      tsd_d <= 1'b0;
      pump_hot_d <= 1'b0;
    end else begin
      ov_d <= s_ov;
      tsd_d <= s_tsd;
      pump_hot_d <= s_pump_hot;
    end
  end
  logic tsd_event; // rising edge of device overtemperature
  assign tsd_event = s_tsd && !tsd_d;

  ////////////////////////////////////////////////////////////////////////////
  // undervoltage reset: falling threshold asserts, rising threshold releases
  logic uv_active; // reset held because of undervoltage
  logic release_ok; // output back above the release threshold
  logic uv_start; // a new undervoltage event this cycle
  logic uv_release; // reset released this cycle
  logic sleeping; // regulator off in sleep or after short
  assign sleeping = (mode == sts_pkg::STS_SLEEP) || !regulator_en;
  // release threshold chosen by hysteresis bit
  assign release_ok = reset_hysteresis_sel ? s_rise_high : s_rise_sel;
  assign uv_start = !uv_active && s_fall && !sleeping;
  assign uv_release = uv_active && release_ok;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      uv_active <= 1'b0;
    end else if (sleeping) begin
      uv_active <= 1'b0;
    end else if (uv_start) begin
      uv_active <= 1'b1;
    end else if (uv_release) begin
      uv_active <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // consecutive undervoltage counter
  logic uv_cnt_run; // counter may advance in this mode
  logic uv_fs_hit; // fourth consecutive event
  assign uv_cnt_run = ((mode == sts_pkg::STS_INIT) || (mode == sts_pkg::STS_STOP) ||
                       (mode == sts_pkg::STS_NORMAL)) &&
                      !((mode == sts_pkg::STS_NORMAL) && s_batt_uv);
  assign uv_fs_hit = uv_start && uv_cnt_run && (uv_count == `STS_UV_FS_COUNT - 3'h1);
  // restart and sleep neither advance nor reset the count
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      uv_count <= 3'h0;
    end else if (uv_fs_hit || (mode == sts_pkg::STS_FAILSAFE) || soft_reset ||
                 (clr_supply_undervolt && !uv_release)) begin
      uv_count <= 3'h0;
    end else if (uv_start && uv_cnt_run) begin
      uv_count <= uv_count + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // short-circuit timer: output must exceed threshold in time
  logic [$clog2(SC_CYCLES+1)-1:0] sc_cnt; // cycles spent below threshold
  logic sc_fault; // timer expired
  logic sc_enable; // detection allowed
  assign sc_enable = regulator_en && !s_batt_uv;
  assign sc_fault = sc_enable && (sc_cnt == ($clog2(SC_CYCLES+1))'(SC_CYCLES));
  // one timer covers start-up and later dips: both mean "below threshold"
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sc_cnt <= '0;
    end else if (!sc_enable || (release_ok && !s_fall)) begin
      sc_cnt <= '0;
    end else if (!sc_fault) begin
      sc_cnt <= sc_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cool-down timer after device thermal shutdown
  localparam int unsigned COOL_W = $clog2(COOL_CYCLES * `STS_COOL_EXT_MULT + 1);
  logic [COOL_W-1:0] cool_cnt; // cycles cooled so far
  logic [COOL_W-1:0] cool_len; // wait length, normal or extended
  logic cool_done; // cool-down finished
  assign cool_len = thermal_safe_flag ? COOL_W'(COOL_CYCLES * `STS_COOL_EXT_MULT) :
                                        COOL_W'(COOL_CYCLES);
  assign cool_done = (cool_cnt >= cool_len);
  // counting only while cool and while held in fail-safe for thermal reasons
  logic tsd_hold; // fail-safe entered by thermal shutdown
  always_ff @(posedge ref_clk) begin
    if (reset || s_tsd || !tsd_hold) begin
      cool_cnt <= '0;
    end else if (!cool_done) begin
      cool_cnt <= cool_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode machine
  logic ov_fs; // overvoltage fail-safe request
  logic go_failsafe; // any fail-safe cause
  assign ov_fs = s_ov && !ov_d && regulator_en &&
                 (overvolt_event_mode == `STS_OV_MODE_FAILSAFE);
  assign go_failsafe = tsd_event || sc_fault || uv_fs_hit || ov_fs;
  // thermal shutdown wins even during sleep entry
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode <= sts_pkg::STS_INIT;
      tsd_hold <= 1'b0;
    end else if (go_failsafe) begin
      mode <= sts_pkg::STS_FAILSAFE;
      tsd_hold <= tsd_event || tsd_hold;
    end else begin
      case (mode)
        sts_pkg::STS_INIT: begin
          if (uv_release) mode <= sts_pkg::STS_RESTART;
          else if (normal_req) mode <= sts_pkg::STS_NORMAL;
          else if (sleep_req) mode <= sts_pkg::STS_SLEEP;
        end
        sts_pkg::STS_NORMAL: begin
          if (uv_release) mode <= sts_pkg::STS_RESTART;
          else if (sleep_req) mode <= sts_pkg::STS_SLEEP;
          else if (stop_req) mode <= sts_pkg::STS_STOP;
        end
        sts_pkg::STS_STOP: begin
          if (uv_release) mode <= sts_pkg::STS_RESTART;
          else if (normal_req) mode <= sts_pkg::STS_NORMAL;
          else if (sleep_req) mode <= sts_pkg::STS_SLEEP;
        end
        sts_pkg::STS_SLEEP: begin
          if (wake_up) mode <= sts_pkg::STS_RESTART;
        end
        sts_pkg::STS_RESTART: begin
          if (!uv_active) mode <= sts_pkg::STS_NORMAL;
        end
        sts_pkg::STS_FAILSAFE: begin
          if (tsd_hold && cool_done) begin
            mode <= sts_pkg::STS_RESTART;
            tsd_hold <= 1'b0;
          end else if (!tsd_hold && wake_up) begin
            mode <= sts_pkg::STS_RESTART;
          end
        end
        default: mode <= sts_pkg::STS_INIT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // regulator enable and fail output
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regulator_en <= 1'b1;
      fail_output_pin <= 1'b0;
    end else if (sc_fault) begin
      regulator_en <= 1'b0;
      fail_output_pin <= 1'b1;
    end else if (sleep_req && mode != sts_pkg::STS_FAILSAFE && !go_failsafe) begin
      regulator_en <= 1'b0; // sleep turns the output off
    end else if (wake_up) begin
      regulator_en <= 1'b1; // only a wake restores the output
      fail_output_pin <= 1'b0;
    end
  end

  // reset pin low while undervoltage reset holds
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reset_output_n <= 1'b0;
    end else begin
      reset_output_n <= !(uv_active || uv_start) && regulator_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overvoltage event output: one-cycle pulse of the chosen type
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      overvolt_event <= 2'h0;
    end else if (s_ov && !ov_d && regulator_en) begin
      overvolt_event <= overvolt_event_mode;
    end else begin
      overvolt_event <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge pump overtemperature sequence
  logic pump_hot_evt; // pump crosses shutdown temperature while on
  assign pump_hot_evt = s_pump_hot && !pump_hot_d && (pump_enable || pump_discharge);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pump_enable <= 1'b0;
      pump_discharge <= 1'b0;
      pump_csa_en <= 1'b0;
    end else if (pump_hot_evt) begin
      pump_enable <= 1'b0;
      pump_discharge <= 1'b1;
    end else if (pump_discharge && xcross_done) begin
      pump_discharge <= 1'b0;
      pump_csa_en <= 1'b0;
    end else if (pump_enable_wr && !s_pump_hot) begin
      pump_enable <= 1'b1; // software must rewrite after cooling
      pump_csa_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal shutdown event counter
  always_ff @(posedge ref_clk) begin
    if (reset || !cooldown_extend_enable || !device_thermal_shutdown_flag && !tsd_event) begin
      tsd_count <= 5'h0;
    end else if (tsd_event && tsd_count != `STS_TSD_SAFE_COUNT) begin
      tsd_count <= tsd_count + 5'h1;
    end
  end

  // device state field
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      device_state_field <= `STS_DEV_STATE_RESET;
    end else if (tsd_event) begin
      device_state_field <= `STS_DEV_STATE_TSD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, all set-wins; software clears are pulses
  localparam int NF = 11;
  sts_flag_if fl[NF] ();
  logic [NF-1:0] f_set;
  logic [NF-1:0] f_clr;
  logic [NF-1:0] f_hold;
  logic [NF-1:0] f_q;
  assign f_set = {
    !sleeping && s_prewarn,
    uv_release && !sleeping,
    uv_fs_hit,
    s_ov && !ov_d && regulator_en,
    sc_fault,
    sc_fault || tsd_event,
    pump_hot_evt,
    pump_hot_evt,
    s_tpw,
    tsd_event,
    cooldown_extend_enable && tsd_event && (tsd_count == `STS_TSD_SAFE_COUNT - 5'h1)
  };
  assign f_clr = {clr_supply_prewarn, clr_supply_undervolt, clr_undervolt_failsafe,
                  clr_supply_overvolt, clr_supply_short, clr_flag_a, clr_block_tsd,
                  clr_pump_overtemp, clr_thermal_prewarn, clr_device_tsd, clr_thermal_safe};
  assign f_hold = {6'h00, s_pump_hot, s_pump_hot, s_tpw,
                   s_tsd || (mode != sts_pkg::STS_NORMAL), 1'b0};
  for (genvar i = 0; i < NF; i++) begin : g_flag
    assign fl[i].set = f_set[i];
    assign fl[i].clr = f_clr[i];
    assign fl[i].hold = f_hold[i];
    assign f_q[i] = fl[i].q;
    sts_flag u_flag (.ref_clk(ref_clk), .reset(reset), .f(fl[i]));
  end
  assign {supply_prewarn_flag, supply_undervolt_flag, undervolt_failsafe_flag,
          supply_overvolt_flag, supply_short_flag, flag_a, block_thermal_shutdown_flag,
          pump_overtemp_flag, thermal_prewarn_flag, device_thermal_shutdown_flag,
          thermal_safe_flag} = f_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_uv_reset_low: assert property (@(posedge ref_clk) disable iff (reset)
    uv_start |=> !reset_output_n) else $error("reset output not low on undervoltage");
  a_uv_fs_entry: assert property (@(posedge ref_clk) disable iff (reset)
    uv_fs_hit |=> (mode == sts_pkg::STS_FAILSAFE) && undervolt_failsafe_flag)
    else $error("fourth undervoltage did not reach fail-safe");
  a_uv_cnt_clear: assert property (@(posedge ref_clk) disable iff (reset)
    (soft_reset && !uv_start) |=> uv_count == 3'h0) else $error("counter not cleared");
  a_uv_cnt_stop: assert property (@(posedge ref_clk) disable iff (reset)
    (mode == sts_pkg::STS_NORMAL && s_batt_uv && !soft_reset && !clr_supply_undervolt)
    |=> $stable(uv_count)) else $error("counter ran with battery low");
  a_uv_cnt_idle: assert property (@(posedge ref_clk) disable iff (reset)
    ((mode == sts_pkg::STS_RESTART || mode == sts_pkg::STS_SLEEP) && !soft_reset &&
    !clr_supply_undervolt) |=> $stable(uv_count)) else $error("counter ran outside its modes");
  a_sleep_no_flag: assert property (@(posedge ref_clk) disable iff (reset)
    (sleeping && !supply_prewarn_flag) |=> !supply_prewarn_flag)
    else $error("prewarn set in sleep");
  a_ov_mode_fs: assert property (@(posedge ref_clk) disable iff (reset)
    ov_fs |=> supply_overvolt_flag && (mode == sts_pkg::STS_FAILSAFE))
    else $error("overvoltage mode 11 missed fail-safe");
  a_sc_response: assert property (@(posedge ref_clk) disable iff (reset)
    sc_fault |=> !regulator_en && fail_output_pin && supply_short_flag && flag_a)
    else $error("short response incomplete");
  a_pump_off: assert property (@(posedge ref_clk) disable iff (reset)
    pump_hot_evt |=> !pump_enable && pump_discharge && pump_overtemp_flag)
    else $error("pump not shut down");
  a_tsd_state: assert property (@(posedge ref_clk) disable iff (reset)
    tsd_event |=> flag_a && device_state_field == 2'h1 && mode == sts_pkg::STS_FAILSAFE)
    else $error("thermal shutdown response wrong");
  a_tsd_clr_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (device_thermal_shutdown_flag && mode != sts_pkg::STS_NORMAL) |=>
    device_thermal_shutdown_flag) else $error("shutdown flag cleared outside normal");
  c_uv_restart: cover property (@(posedge ref_clk) uv_release ##1 mode == sts_pkg::STS_RESTART);
  c_uv_fs: cover property (@(posedge ref_clk) uv_fs_hit);
  c_sc: cover property (@(posedge ref_clk) sc_fault);
  c_tsd_safe: cover property (@(posedge ref_clk) $rose(thermal_safe_flag));
endmodule

// File: hw/sts_consts.svh
`ifndef STS_CONSTS_SVH
`define STS_CONSTS_SVH
// clock rate and times
`define STS_CLK_HZ 25000000
`define STS_SC_TIME_US 4000
`define STS_SC_CYCLES ((`STS_CLK_HZ / 1000000) * `STS_SC_TIME_US)
`define STS_COOL_TIME_US 1000000
`define STS_COOL_CYCLES ((`STS_CLK_HZ / 1000000) * `STS_COOL_TIME_US)
`define STS_COOL_EXT_MULT 64
// counts
`define STS_UV_FS_COUNT 3'h4
`define STS_TSD_SAFE_COUNT 5'h10
// overvoltage mode codes
`define STS_OV_MODE_FAILSAFE 2'h3
// device status field values after thermal shutdown and after reset
`define STS_DEV_STATE_TSD 2'h1
`define STS_DEV_STATE_RESET 2'h0
`endif

// File: hw/sts_pkg.sv
package sts_pkg;
  // operating modes, one-hot
  typedef enum logic [5:0] {
    STS_INIT = 6'h01,
    STS_NORMAL = 6'h02,
    STS_STOP = 6'h04,
    STS_SLEEP = 6'h08,
    STS_RESTART = 6'h10,
    STS_FAILSAFE = 6'h20
  } sts_mode_type;
endpackage

// File: hw/sts_flag_if.sv
`timescale 1ns/1ps
// set/clear/hold/state bundle for one sticky flag
interface sts_flag_if;
  logic set; // hardware event
  logic clr; // software clear
  logic hold; // clear blocked while condition stands
  logic q; // flag state
  modport owner(input set, input clr, input hold, output q);
  modport user(output set, output clr, output hold, input q);
endinterface

// File: hw/sts_flag.sv
`timescale 1ns/1ps
// one sticky status flag: set wins over clear
module sts_flag (
  input wire logic ref_clk,
  input wire logic reset,
  sts_flag_if.owner f
);
  // clear only when no set this cycle and the condition is gone
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      f.q <= 1'b0;
    end else if (f.set) begin
      f.q <= 1'b1;
    end else if (f.clr && !f.hold) begin
      f.q <= 1'b0;
    end
  end
endmodule

// File: tb/sts_mcu_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// software side: reads the sticky flags and clears what it saw
module sts_mcu_model (
  input wire logic ref_clk,
  input wire logic service, // one read-and-clear pass
  input wire logic pump_req, // rewrite pump enable
  input wire logic [10:0] fl,
  output logic [10:0] clr,
  output logic pump_enable_wr
);
  initial {clr, pump_enable_wr} = 12'h000;
  // clear only the flags that were read; pulses last one edge
  always @(posedge ref_clk) begin
    clr <= service ? fl : 11'h000;
    pump_enable_wr <= pump_req;
  end
endmodule

// File: tb/sts_supervisor_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module sts_supervisor_tb;
  localparam sts_pkg::sts_mode_type FS = sts_pkg::STS_FAILSAFE;
  localparam sts_pkg::sts_mode_type NM = sts_pkg::STS_NORMAL;
  logic ref_clk, reset, reset_hysteresis_sel, cooldown_extend_enable, xcross_done;
  logic soft_reset, sleep_req, service, pump_req, pump_enable_wr, wake_up, stop_req;
  logic cmp_prewarn_low, cmp_below_fall, cmp_above_rise_sel, cmp_above_rise_high;
  logic cmp_overvolt, cmp_batt_uv, cmp_pump_hot, cmp_temp_prewarn, cmp_temp_shutdown;
  logic reset_output_n, regulator_en, fail_output_pin, pump_enable, pump_discharge, pump_csa_en;
  logic [1:0] overvolt_event_mode, overvolt_event, device_state_field, cap;
  logic [2:0] uv_count;
  logic [4:0] tsd_count;
  logic [10:0] fl, clr; // flags and clears, same bit order
  sts_pkg::sts_mode_type mode;
  int mismatches = 0;
  int checks = 0;
  // short times keep the run small
  sts_supervisor #(.SC_CYCLES(20), .COOL_CYCLES(50)) dut (
    .ref_clk, .reset, .cmp_prewarn_low, .cmp_below_fall, .cmp_above_rise_sel,
    .cmp_above_rise_high, .cmp_overvolt, .cmp_batt_uv, .cmp_pump_hot, .cmp_temp_prewarn,
    .cmp_temp_shutdown, .reset_hysteresis_sel, .overvolt_event_mode, .cooldown_extend_enable,
    .pump_enable_wr, .xcross_done, .soft_reset, .wake_up, .sleep_req, .stop_req,
    .normal_req(1'h0), .clr_supply_prewarn(clr[10]), .clr_supply_undervolt(clr[9]),
    .clr_undervolt_failsafe(clr[8]), .clr_supply_overvolt(clr[7]), .clr_supply_short(clr[6]),
    .clr_flag_a(clr[5]), .clr_block_tsd(clr[4]), .clr_pump_overtemp(clr[3]),
    .clr_thermal_prewarn(clr[2]), .clr_device_tsd(clr[1]), .clr_thermal_safe(clr[0]),
    .reset_output_n, .regulator_en, .fail_output_pin, .pump_enable, .pump_discharge,
    .pump_csa_en, .overvolt_event, .mode, .device_state_field, .uv_count, .tsd_count,
    .supply_prewarn_flag(fl[10]), .supply_undervolt_flag(fl[9]),
    .undervolt_failsafe_flag(fl[8]), .supply_overvolt_flag(fl[7]), .supply_short_flag(fl[6]),
    .flag_a(fl[5]), .block_thermal_shutdown_flag(fl[4]), .pump_overtemp_flag(fl[3]),
    .thermal_prewarn_flag(fl[2]), .device_thermal_shutdown_flag(fl[1]),
    .thermal_safe_flag(fl[0]));
  sts_mcu_model mcu (.ref_clk, .service, .pump_req, .fl, .clr, .pump_enable_wr);
  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // inputs only move at falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic ck(input logic [7:0] got, input logic [7:0] exp, input string w);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for a mode; running out ends the run
  task automatic wait_mode(input sts_pkg::sts_mode_type m, input int n);
    while (mode !== m && n > 0) begin
      cyc(1);
      n--;
    end
    if (mode !== m) begin
      mismatches++;
      $display("BAD t=%0t mode wait", $time);
      report_and_stop();
    end
  endtask
  // three edges of reset: the synchronisers need them
  task automatic rst();
    reset = 1'h1;
    {cmp_prewarn_low, cmp_below_fall, cmp_overvolt, cmp_batt_uv, cmp_pump_hot} = 5'h00;
    {cmp_temp_prewarn, cmp_temp_shutdown, soft_reset, sleep_req, service, pump_req} = 6'h00;
    {wake_up, stop_req} = 2'h0;
    {cmp_above_rise_sel, cmp_above_rise_high, reset_hysteresis_sel} = 3'h6;
    {overvolt_event_mode, cooldown_extend_enable, xcross_done} = 4'h0;
    cyc(3);
    reset = 1'h0;
    cyc(6);
  endtask
  // dip kept well under the short time
  task automatic uv_dn();
    {cmp_below_fall, cmp_above_rise_sel, cmp_above_rise_high} = 3'h4;
    cyc(5);
  endtask
  task automatic uv_up();
    {cmp_below_fall, cmp_above_rise_sel, cmp_above_rise_high} = 3'h3;
    cyc(6);
  endtask
  task automatic svc();
    service = 1'h1;
    cyc(1);
    service = 1'h0;
    cyc(3);
  endtask
  task automatic pulse_pump();
    pump_req = 1'h1;
    cyc(1);
    pump_req = 1'h0;
    cyc(3);
  endtask
  // one-cycle request pulse on any control input
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst();
    cmp_prewarn_low = 1'h1;
    cyc(5);
    ck(fl[10], 1, "pw");
    ck(mode, sts_pkg::STS_INIT, "pw mode");
    uv_dn();
    ck(reset_output_n, 0, "uv rst");
    ck(uv_count, 1, "uv cnt");
    uv_up();
    ck({reset_output_n, fl[9]}, 3, "uv rel");
    ck(mode, NM, "uv mode");
    reset_hysteresis_sel = 1'h1;
    uv_dn();
    {cmp_below_fall, cmp_above_rise_sel} = 2'h1;
    cyc(6);
    ck(reset_output_n, 0, "hys hold");
    cmp_above_rise_high = 1'h1;
    cyc(6);
    ck(reset_output_n, 1, "hys rel");
    ck(uv_count, 2, "cnt2");
    // weak battery: counter and short timer both stop
    cmp_batt_uv = 1'h1;
    uv_dn();
    cyc(40);
    ck(uv_count, 2, "cnt held");
    ck(fl[6], 0, "no short");
    uv_up();
    cmp_batt_uv = 1'h0;
    uv_dn();
    uv_up();
    uv_dn();
    ck({mode == FS, fl[8]}, 3, "uv fs");
    ck(uv_count, 0, "fs cnt");
    $display("end undervoltage");
    rst();
    uv_dn();
    uv_up();
    svc();
    ck({fl[9], uv_count}, 0, "clr cnt");
    uv_dn();
    uv_up();
    pulse(soft_reset);
    ck(uv_count, 0, "soft cnt");
    // stop mode still counts undervoltage events
    pulse(stop_req);
    uv_dn();
    ck(mode, sts_pkg::STS_STOP, "stop mode");
    ck(uv_count, 1, "stop cnt");
    uv_up();
    svc();
    pulse(sleep_req);
    cmp_prewarn_low = 1'h1;
    uv_dn();
    cyc(5);
    ck({fl[10], fl[9]}, 0, "sleep");
    ck(uv_count, 0, "sleep cnt");
    $display("end clear and sleep");
    for (int m = 0; m < 4; m++) begin
      rst();
      overvolt_event_mode = m[1:0];
      cmp_overvolt = 1'h1;
      cap = 2'h0;
      repeat (6) begin
        cyc(1);
        cap = cap | overvolt_event;
      end
      ck(cap, m[7:0], "ov ev");
      ck({fl[7], mode == FS}, {1'h1, m == 3}, "ov");
    end
    $display("end overvoltage");
    rst();
    reset = 1'h1;
    {cmp_above_rise_sel, cmp_above_rise_high} = 2'h0;
    cyc(3);
    reset = 1'h0;
    cyc(40);
    ck({fl[6], fail_output_pin, regulator_en, fl[5]}, 4'hD, "sc up");
    ck(mode, FS, "sc mode");
    pulse(wake_up);
    ck({regulator_en, fail_output_pin, mode == NM}, 5, "sc wake");
    rst();
    uv_dn();
    cyc(40);
    ck({fl[6], fail_output_pin, mode == FS}, 7, "sc low");
    $display("end short");
    rst();
    // pump off: its overtemperature must stay silent
    cmp_pump_hot = 1'h1;
    cyc(5);
    ck({fl[4], fl[3]}, 0, "cp idle");
    cmp_pump_hot = 1'h0;
    cyc(3);
    pulse_pump();
    ck(pump_enable, 1, "cp on");
    cmp_pump_hot = 1'h1;
    cyc(5);
    ck({pump_enable, fl[3], fl[4], pump_discharge}, 7, "cp hot");
    xcross_done = 1'h1;
    cyc(3);
    ck({pump_discharge, pump_csa_en}, 0, "cp off");
    svc();
    ck(fl[3], 1, "cp hold");
    cmp_pump_hot = 1'h0;
    cmp_temp_prewarn = 1'h1;
    cyc(5);
    svc();
    ck({fl[3], fl[4], fl[2]}, 1, "cp clr");
    pulse_pump();
    ck(pump_enable, 1, "cp again");
    cmp_temp_prewarn = 1'h0;
    cyc(3);
    svc();
    ck(fl[2], 0, "tp clr");
    $display("end pump and prewarn");
    rst();
    cmp_temp_shutdown = 1'h1;
    cyc(5);
    ck({mode == FS, fl[1], fl[5], device_state_field}, 5'h1D, "tsd");
    cmp_temp_shutdown = 1'h0;
    cyc(30);
    svc();
    ck({mode == FS, fl[1]}, 3, "cool");
    wait_mode(NM, 60);
    svc();
    ck(fl[1], 0, "tsd clr");
    // sixteen quick events: the first enters fail-safe from normal, the rest come before cool-down ends
    cooldown_extend_enable = 1'h1;
    repeat (16) begin
      cmp_temp_shutdown = 1'h1;
      cyc(4);
      cmp_temp_shutdown = 1'h0;
      cyc(4);
    end
    ck({fl[0], tsd_count}, 6'h30, "safe");
    cyc(1000);
    ck(mode, FS, "ext");
    wait_mode(NM, 3000);
    svc();
    ck({fl[0], tsd_count}, 0, "cnt clr");
    $display("end thermal");
    report_and_stop();
  end
endmodule
